/* core/bwhdp_top.sv */
// byte-wide host data port: peripheral bus registers and host pin logic
`timescale 1ns/1ps
// What this block does
// - store loads outbound word; host reads bytes
// - load returns inbound word; host writes bytes
// - status resets to 0x0301
// - status bits 15-11 ignore writes
// - stall enabled access while buffer not ready
// - bit 9 masks outbound ready output high
// - bit 8 masks inbound ready output high
// - host data read while not ready sets error
// - host data write while not free sets error
// - store while ready sets store error
// - load while free sets load error
// - error flags sticky until reset or zero-write
// - ready sets on store, clears upper read
// - free sets on load, clears upper write
// - host address lines select register and byte
// - host read and write address decode
// - store drives outbound ready output low
// - upper read clears ready, raises drained irq
// - data bus released while select high
// - ready output rises on upper read strobe fall
// - upper write clears free, raises filled irq
module bwhdp_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire bwhdp_pkg::bwhdp_cpu_req_type cpu_req,
  output logic [15:0] cpu_rdata,
  output logic cpu_wait,
  input wire bwhdp_pkg::bwhdp_host_in_type host_in,
  output logic [7:0] port_data_bus_o,
  output logic port_data_bus_oe,
  output logic outbound_ready_n,
  output logic inbound_free_n,
  output logic outbound_drained_irq,
  output logic inbound_filled_irq
);
  import bwhdp_pkg::*;

  logic [15:0] out_buf_q;
  logic [15:0] in_buf_q;
  logic access_stall_enable_q;
  logic outbound_ready_mask_q;
  logic inbound_free_mask_q;
  logic user_flag_b_q;
  logic user_flag_a_q;
  logic host_read_error_q;
  logic host_write_error_q;
  logic store_error_q;
  logic load_error_q;
  logic outbound_ready_flag_q;
  logic inbound_free_flag_q;
  logic rd_strobe_q;
  logic wr_strobe_q;
  logic [15:0] status_word;
  logic data_sel;
  logic stat_sel;
  logic store_req;
  logic load_req;
  logic store_go;
  logic load_go;
  logic stat_wr;
  logic host_rd_act;
  logic host_wr_act;
  logic host_rd_fall;
  logic host_wr_rise;
  logic host_wr_fall;
  logic host_rd_hi_fall;
  logic host_wr_hi_fall;
  bwhdp_addr_type host_addr;

  // equality helper shared by both register decodes
  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] ref_a);
    addr_hit = (a == ref_a);
  endfunction

  // strobe edge aimed at the upper data byte; this is what moves the flags
  function automatic logic upper_data_edge(input logic edge_seen, input logic [1:0] a);
    return edge_seen && (a == BWHDP_ADDR_DATA_HI);
  endfunction

  assign data_sel = addr_hit(cpu_req.addr, DATA_PORT_ADDR);
  assign stat_sel = addr_hit(cpu_req.addr, STATUS_PORT_ADDR);
  assign store_req = cpu_req.wr && data_sel;
  assign load_req = cpu_req.rd && data_sel;
  assign stat_wr = cpu_req.wr && stat_sel;

  // a stalled access retries each cycle; it takes effect only when released
  always_comb begin
    cpu_wait = 1'b0;
    if (access_stall_enable_q) begin
      if (store_req && outbound_ready_flag_q) begin
        cpu_wait = 1'b1;
      end else if (load_req && inbound_free_flag_q) begin
        cpu_wait = 1'b1;
      end
    end
  end
  assign store_go = store_req && !cpu_wait;
  assign load_go = load_req && !cpu_wait;

  // host decode; both strobes low selects nothing
  assign host_addr = bwhdp_addr_type'({host_in.reg_select, host_in.byte_select});
  assign host_rd_act = !host_in.port_select_n && !host_in.read_strobe_n
                       && host_in.write_strobe_n;
  assign host_wr_act = !host_in.port_select_n && !host_in.write_strobe_n
                       && host_in.read_strobe_n;
  assign host_rd_fall = host_rd_act && !rd_strobe_q;
  // write data latched at strobe end, when the host data is settled
  assign host_wr_rise = wr_strobe_q && !host_wr_act;
  assign host_wr_fall = host_wr_act && !wr_strobe_q;
  assign host_rd_hi_fall = upper_data_edge(host_rd_fall, host_addr);
  assign host_wr_hi_fall = upper_data_edge(host_wr_fall, host_addr);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_strobe_q <= 1'b0;
      wr_strobe_q <= 1'b0;
    end else begin
      rd_strobe_q <= host_rd_act;
      wr_strobe_q <= host_wr_act;
    end
  end

  logic [1:0] wr_addr_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_addr_q <= 2'h0;
    end else if (host_wr_act) begin
      wr_addr_q <= host_addr;
    end
  end

  logic [7:0] wr_data_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_data_q <= 8'h00;
    end else if (host_wr_act) begin
      wr_data_q <= host_in.data_in;
    end
  end

  logic host_wr_data_lo;
  logic host_wr_data_hi;
  assign host_wr_data_lo = host_wr_rise && (wr_addr_q == BWHDP_ADDR_DATA_LO);
  assign host_wr_data_hi = host_wr_rise && (wr_addr_q == BWHDP_ADDR_DATA_HI);

  // outbound word
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_buf_q <= 16'h0000;
    end else if (store_go) begin
      out_buf_q <= cpu_req.wdata;
    end
  end

  // inbound word, filled byte by byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      in_buf_q <= 16'h0000;
    end else if (host_wr_data_lo) begin
      in_buf_q[7:0] <= wr_data_q;
    end else if (host_wr_data_hi) begin
      in_buf_q[15:8] <= wr_data_q;
    end
  end

  assign status_word = {RSVD_READ, access_stall_enable_q, outbound_ready_mask_q,
                        inbound_free_mask_q, user_flag_b_q, user_flag_a_q,
                        host_read_error_q, host_write_error_q, store_error_q,
                        load_error_q, outbound_ready_flag_q, inbound_free_flag_q};

  // control bits; reserved bits have no storage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      access_stall_enable_q <= STATUS_RESET[BIT_STALL_EN];
      outbound_ready_mask_q <= STATUS_RESET[BIT_OUT_MASK];
      inbound_free_mask_q <= STATUS_RESET[BIT_IN_MASK];
      user_flag_b_q <= STATUS_RESET[BIT_USER_B];
      user_flag_a_q <= STATUS_RESET[BIT_USER_A];
    end else if (stat_wr) begin
      access_stall_enable_q <= cpu_req.wdata[BIT_STALL_EN];
      outbound_ready_mask_q <= cpu_req.wdata[BIT_OUT_MASK];
      inbound_free_mask_q <= cpu_req.wdata[BIT_IN_MASK];
      user_flag_b_q <= cpu_req.wdata[BIT_USER_B];
      user_flag_a_q <= cpu_req.wdata[BIT_USER_A];
    end
  end

  // sticky errors: a set in the same cycle as a program clear wins
  logic hrd_err_set;
  logic hwr_err_set;
  assign hrd_err_set = host_rd_fall && !host_addr[1] && !outbound_ready_flag_q;
  // checked at strobe fall: an upper write clears the free flag on that same edge
  assign hwr_err_set = host_wr_fall && !host_addr[1] && !inbound_free_flag_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      host_read_error_q <= STATUS_RESET[BIT_HRD_ERR];
      host_write_error_q <= STATUS_RESET[BIT_HWR_ERR];
      store_error_q <= STATUS_RESET[BIT_ST_ERR];
      load_error_q <= STATUS_RESET[BIT_LD_ERR];
    end else begin
      if (hrd_err_set) begin
        host_read_error_q <= 1'b1;
      end else if (stat_wr) begin
        host_read_error_q <= host_read_error_q & cpu_req.wdata[BIT_HRD_ERR];
      end
      if (hwr_err_set) begin
        host_write_error_q <= 1'b1;
      end else if (stat_wr) begin
        host_write_error_q <= host_write_error_q & cpu_req.wdata[BIT_HWR_ERR];
      end
      if (store_go && outbound_ready_flag_q) begin
        store_error_q <= 1'b1;
      end else if (stat_wr) begin
        store_error_q <= store_error_q & cpu_req.wdata[BIT_ST_ERR];
      end
      if (load_go && inbound_free_flag_q) begin
        load_error_q <= 1'b1;
      end else if (stat_wr) begin
        load_error_q <= load_error_q & cpu_req.wdata[BIT_LD_ERR];
      end
    end
  end

  // handshake flags; program writes to them are ignored
  // a store in the same cycle as an upper read wins; the new word is kept
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      outbound_ready_flag_q <= STATUS_RESET[BIT_OUT_RDY];
    end else if (store_go) begin
      outbound_ready_flag_q <= 1'b1;
    end else if (host_rd_hi_fall) begin
      outbound_ready_flag_q <= 1'b0;
    end
  end

  // free flag drops at the upper strobe fall so a second word cannot slip in
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      inbound_free_flag_q <= STATUS_RESET[BIT_IN_FREE];
    end else if (load_go) begin
      inbound_free_flag_q <= 1'b1;
    end else if (host_wr_hi_fall) begin
      inbound_free_flag_q <= 1'b0;
    end
  end

  // interrupt pulses, one cycle each
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      outbound_drained_irq <= 1'b0;
    end else begin
      outbound_drained_irq <= host_rd_hi_fall;
    end
  end

  // filled pulse waits for the committed byte, so a handler loads a whole word
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      inbound_filled_irq <= 1'b0;
    end else begin
      inbound_filled_irq <= host_wr_data_hi;
    end
  end

  // ready pins from flops: forced high in reset; masks reset to 1 keep them high after
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      outbound_ready_n <= 1'b1;
      inbound_free_n <= 1'b1;
    end else begin
      outbound_ready_n <= !(outbound_ready_flag_d() && !outbound_ready_mask_d());
      inbound_free_n <= !(inbound_free_flag_d() && !inbound_free_mask_d());
    end
  end

  // next values so the pins move on the same edge as the flags
  function automatic logic outbound_ready_flag_d();
    if (store_go) begin
      return 1'b1;
    end else if (host_rd_hi_fall) begin
      return 1'b0;
    end
    return outbound_ready_flag_q;
  endfunction

  function automatic logic inbound_free_flag_d();
    if (load_go) begin
      return 1'b1;
    end else if (host_wr_hi_fall) begin
      return 1'b0;
    end
    return inbound_free_flag_q;
  endfunction

  function automatic logic outbound_ready_mask_d();
    return stat_wr ? cpu_req.wdata[BIT_OUT_MASK] : outbound_ready_mask_q;
  endfunction

  function automatic logic inbound_free_mask_d();
    return stat_wr ? cpu_req.wdata[BIT_IN_MASK] : inbound_free_mask_q;
  endfunction

  // host read data, registered
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      port_data_bus_o <= 8'h00;
    end else if (host_rd_act) begin
      unique case (host_addr)
        BWHDP_ADDR_DATA_LO: port_data_bus_o <= out_buf_q[7:0];
        BWHDP_ADDR_DATA_HI: port_data_bus_o <= out_buf_q[15:8];
        BWHDP_ADDR_STAT_LO: port_data_bus_o <= status_word[7:0];
        BWHDP_ADDR_STAT_HI: port_data_bus_o <= status_word[15:8];
      endcase
    end
  end

  // drive only during a qualified read cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      port_data_bus_oe <= 1'b0;
    end else begin
      port_data_bus_oe <= host_rd_act;
    end
  end

  // processor read data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cpu_rdata <= 16'h0000;
    end else if (load_go) begin
      cpu_rdata <= in_buf_q;
    end else if (cpu_req.rd && stat_sel) begin
      cpu_rdata <= status_word;
    end
  end
endmodule // bwhdp_top

/* core/bwhdp_pkg.sv */
// constants and types for the byte-wide host data port
package bwhdp_pkg;
  localparam logic [15:0] DATA_PORT_ADDR = 16'h3806;
  localparam logic [15:0] STATUS_PORT_ADDR = 16'h3807;
  localparam logic [15:0] STATUS_RESET = 16'h0301;
  localparam int BIT_STALL_EN = 10;
  localparam int BIT_OUT_MASK = 9;
  localparam int BIT_IN_MASK = 8;
  localparam int BIT_USER_B = 7;
  localparam int BIT_USER_A = 6;
  localparam int BIT_HRD_ERR = 5;
  localparam int BIT_HWR_ERR = 4;
  localparam int BIT_ST_ERR = 3;
  localparam int BIT_LD_ERR = 2;
  localparam int BIT_OUT_RDY = 1;
  localparam int BIT_IN_FREE = 0;
  localparam int RSVD_LSB = 11;
  localparam logic [4:0] RSVD_READ = 5'h00;

  typedef enum logic [1:0] {
    BWHDP_ADDR_DATA_LO = 2'h0,
    BWHDP_ADDR_DATA_HI = 2'h1,
    BWHDP_ADDR_STAT_LO = 2'h2,
    BWHDP_ADDR_STAT_HI = 2'h3
  } bwhdp_addr_type;

  // processor side peripheral bus access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bwhdp_cpu_req_type;

  // host pins sampled on clk_sys
  typedef struct packed {
    logic port_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic reg_select;
    logic byte_select;
    logic [7:0] data_in;
  } bwhdp_host_in_type;
endpackage

/* verification/bwhdp_top_asserts.sv */
// concurrent checks on the host port pins and processor bus
`timescale 1ns/1ps
module bwhdp_top_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire bwhdp_pkg::bwhdp_cpu_req_type cpu_req,
  input wire logic [15:0] cpu_rdata,
  input wire logic cpu_wait,
  input wire bwhdp_pkg::bwhdp_host_in_type host_in,
  input wire logic [7:0] port_data_bus_o,
  input wire logic port_data_bus_oe,
  input wire logic outbound_ready_n,
  input wire logic inbound_free_n,
  input wire logic outbound_drained_irq,
  input wire logic inbound_filled_irq
);
  import bwhdp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_rd(logic [1:0] a);
    !host_in.port_select_n && !host_in.read_strobe_n && host_in.write_strobe_n &&
      {host_in.reg_select, host_in.byte_select} == a;
  endsequence
  sequence s_any_rd;
    !host_in.port_select_n && !host_in.read_strobe_n && host_in.write_strobe_n;
  endsequence
  property p_rst;
    disable iff (1'b0) !rst_n |=> outbound_ready_n && inbound_free_n && !port_data_bus_oe &&
      !outbound_drained_irq && !inbound_filled_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pin state wrong");
  property p_float;
    host_in.port_select_n |=> !port_data_bus_oe;
  endproperty
  a_float: assert property (p_float) else $error("bus driven while deselected");
  property p_drive;
    s_any_rd |=> port_data_bus_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("read not driven");
  property p_nowr;
    !host_in.port_select_n && !host_in.write_strobe_n |=> !port_data_bus_oe;
  endproperty
  a_nowr: assert property (p_nowr) else $error("bus driven during write");
  property p_drain;
    outbound_drained_irq |-> $past(host_in.byte_select) && outbound_ready_n
      ##1 !outbound_drained_irq;
  endproperty
  a_drain: assert property (p_drain) else $error("drained pulse wrong");
  property p_filled;
    inbound_filled_irq |-> inbound_free_n ##1 !inbound_filled_irq;
  endproperty
  a_filled: assert property (p_filled) else $error("filled pulse wrong");
  property p_stat_hi;
    s_rd(2'h3) ##1 port_data_bus_oe |-> port_data_bus_o[7:3] == RSVD_READ;
  endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("reserved bits seen");
  property p_lo_keep;
    s_rd(2'h0) and !cpu_req.wr |=> $stable(outbound_ready_n);
  endproperty
  a_lo_keep: assert property (p_lo_keep) else $error("lower read moved ready");
  property p_wait;
    cpu_wait |-> (cpu_req.rd || cpu_req.wr) && cpu_req.addr == DATA_PORT_ADDR;
  endproperty
  a_wait: assert property (p_wait) else $error("stall without data access");
  property p_cpu_rsvd;
    cpu_req.rd && !cpu_wait && cpu_req.addr == STATUS_PORT_ADDR |=>
      cpu_rdata[15:11] == RSVD_READ;
  endproperty
  a_cpu_rsvd: assert property (p_cpu_rsvd) else $error("reserved status bits set");
endmodule // bwhdp_top_asserts
bind bwhdp_top bwhdp_top_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .cpu_req(cpu_req),
  .cpu_rdata(cpu_rdata), .cpu_wait(cpu_wait), .host_in(host_in),
  .port_data_bus_o(port_data_bus_o), .port_data_bus_oe(port_data_bus_oe),
  .outbound_ready_n(outbound_ready_n), .inbound_free_n(inbound_free_n),
  .outbound_drained_irq(outbound_drained_irq), .inbound_filled_irq(inbound_filled_irq));

/* verification/bwhdp_host_model.sv */
// host cpu model driving the byte-wide port pins
`timescale 1ns/1ps
module bwhdp_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] port_data_bus_o,
  input wire logic port_data_bus_oe,
  output bwhdp_pkg::bwhdp_host_in_type host_in
);
  import bwhdp_pkg::*;
  initial begin
    host_in = 13'h1c00;
  end
  task automatic host_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys) #1;
    {host_in.reg_select, host_in.byte_select} = a;
    host_in.port_select_n = 1'b0;
    host_in.read_strobe_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    d = port_data_bus_oe ? port_data_bus_o : 8'hzz;
    host_in.read_strobe_n = 1'b1;
    host_in.port_select_n = 1'b1;
  endtask
  task automatic host_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    {host_in.reg_select, host_in.byte_select} = a;
    host_in.data_in = d;
    host_in.port_select_n = 1'b0;
    host_in.write_strobe_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    host_in.write_strobe_n = 1'b1;
    host_in.port_select_n = 1'b1;
    // released lines show junk, not the last byte
    host_in.data_in = ~d;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule // bwhdp_host_model

/* verification/tb_bwhdp_top.sv */
// self-checking bench for the byte-wide host data port
`timescale 1ns/1ps
module tb_bwhdp_top;
  import bwhdp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  bwhdp_cpu_req_type cpu_req = '0;
  bwhdp_host_in_type host_in;
  logic [15:0] cpu_rdata, rd;
  logic [7:0] port_data_bus_o, hd;
  logic cpu_wait, port_data_bus_oe, outbound_ready_n, inbound_free_n;
  logic outbound_drained_irq, inbound_filled_irq;
  logic saw_wait = 1'b0;
  int miscompares = 0;
  int n_tests = 0;
  int n_drain = 0;
  int n_fill = 0;
  always #20 clk_sys = ~clk_sys;
  // pulses are too short for the tasks to see, so they are counted here
  always @(posedge clk_sys) begin
    if (outbound_drained_irq === 1'b1) n_drain++;
    if (inbound_filled_irq === 1'b1) n_fill++;
  end
  bwhdp_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .cpu_wait(cpu_wait), .host_in(host_in), .port_data_bus_o(port_data_bus_o),
    .port_data_bus_oe(port_data_bus_oe), .outbound_ready_n(outbound_ready_n),
    .inbound_free_n(inbound_free_n), .outbound_drained_irq(outbound_drained_irq),
    .inbound_filled_irq(inbound_filled_irq));
  bwhdp_host_model host (.clk_sys(clk_sys), .port_data_bus_o(port_data_bus_o),
    .port_data_bus_oe(port_data_bus_oe), .host_in(host_in));
  task automatic end_sim();
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one processor read or write, data or status, held while stalled
  task automatic cpu_acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_sys) #1;
    cpu_req.rd = !w;
    cpu_req.wr = w;
    cpu_req.addr = a;
    cpu_req.wdata = d;
    #1;
    while (cpu_wait !== 1'b0) begin
      saw_wait = 1'b1;
      n++;
      if (n > 200) begin
        miscompares++;
        end_sim();
      end
      @(posedge clk_sys) #1;
    end
    @(posedge clk_sys) #1;
    rd = cpu_rdata;
    cpu_req.rd = 1'b0;
    cpu_req.wr = 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    cpu_acc(1'b0, STATUS_PORT_ADDR, 16'h0);
    chk(rd, STATUS_RESET);
    chk({14'h0, outbound_ready_n, inbound_free_n}, 16'h0003);
    cpu_acc(1'b1, STATUS_PORT_ADDR, 16'hf8fc);
    cpu_acc(1'b0, STATUS_PORT_ADDR, 16'h0);
    chk(rd, 16'h00c1);
    chk({15'h0, inbound_free_n}, 16'h0000);
    cpu_acc(1'b1, DATA_PORT_ADDR, 16'ha55a);
    @(posedge clk_sys) #1;
    chk({15'h0, outbound_ready_n}, 16'h0000);
    host.host_rd(2'h0, hd);
    chk({8'h0, hd}, 16'h005a);
    chk({15'h0, outbound_ready_n}, 16'h0000);
    host.host_rd(2'h1, hd);
    chk({8'h0, hd}, 16'h00a5);
    chk({15'h0, outbound_ready_n}, 16'h0001);
    host.host_rd(2'h2, hd);
    chk({8'h0, hd}, 16'h00c1);
    host.host_rd(2'h1, hd);
    cpu_acc(1'b0, DATA_PORT_ADDR, 16'h0);
    host.host_wr(2'h0, 8'h34);
    host.host_wr(2'h1, 8'h12);
    chk({15'h0, inbound_free_n}, 16'h0001);
    cpu_acc(1'b0, STATUS_PORT_ADDR, 16'h0);
    chk(rd, 16'h00e4);
    cpu_acc(1'b0, DATA_PORT_ADDR, 16'h0);
    chk(rd, 16'h1234);
    @(posedge clk_sys) #1;
    chk({15'h0, inbound_free_n}, 16'h0000);
    host.host_wr(2'h1, 8'h77);
    host.host_wr(2'h1, 8'h88);
    // status writes from the host are disabled
    host.host_wr(2'h2, 8'h00);
    cpu_acc(1'b0, DATA_PORT_ADDR, 16'h0);
    cpu_acc(1'b1, DATA_PORT_ADDR, 16'h1111);
    cpu_acc(1'b1, DATA_PORT_ADDR, 16'h2222);
    cpu_acc(1'b0, STATUS_PORT_ADDR, 16'h0);
    chk(rd, 16'h00ff);
    cpu_acc(1'b1, STATUS_PORT_ADDR, 16'h00c0);
    cpu_acc(1'b0, STATUS_PORT_ADDR, 16'h0);
    chk(rd, 16'h00c3);
    host.host_rd(2'h1, hd);
    cpu_acc(1'b1, STATUS_PORT_ADDR, 16'h0700);
    cpu_acc(1'b1, DATA_PORT_ADDR, 16'h3333);
    @(posedge clk_sys) #1;
    chk({14'h0, outbound_ready_n, inbound_free_n}, 16'h0003);
    fork
      cpu_acc(1'b1, DATA_PORT_ADDR, 16'h4444);
      begin
        repeat (4) @(posedge clk_sys);
        host.host_rd(2'h1, hd);
      end
    join
    chk({15'h0, saw_wait}, 16'h0001);
    cpu_acc(1'b0, STATUS_PORT_ADDR, 16'h0);
    chk(rd, 16'h0703);
    host.host_rd(2'h3, hd);
    chk({8'h0, hd}, 16'h0007);
    host.host_rd(2'h1, hd);
    chk({8'h0, hd}, 16'h0044);
    chk(n_drain[15:0], 16'h0005);
    chk(n_fill[15:0], 16'h0003);
    end_sim();
  end
endmodule // tb_bwhdp_top
